// *** hw/pin_sync.v ***
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    input wire clk_sys,
    input wire resetn,
    input wire clk_en,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_r;

// ----------------------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------------------
// First stage feeds only the second stage
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        meta_r <= RST_VAL;
        q <= RST_VAL;
    end else if (clk_en) begin
        meta_r <= d;
        q <= meta_r;
    end
end

endmodule // pin_sync

// *** hw/sampling_adc_host_interface.v ***
`include "sampling_adc_defs.vh"

module sampling_adc_host_interface #(
    parameter CONV_CLKS = `CONV_CLKS_DEF,
    parameter INT_HALF = `INT_HALF_DEF
) (
    input wire clk_sys,
    input wire resetn,
    input wire clk_en,
    input wire convert_start_n,
    input wire cs_n,
    input wire rd_n,
    input wire [`RES_W-1:0] db_in,
    input wire conv_clk_ext,
    input wire use_ext_clk,
    input wire [`FMT_W-1:0] format_sel,
    input wire unipolar_range,
    input wire [`RES_W-1:0] adc_code,
    output reg [`RES_W-1:0] db_out,
    output reg [`RES_W-1:0] db_oe,
    output reg busy_int_n,
    output reg track_hold
);

// ----------------------------------------------------------------------------
// Constants and functions
// ----------------------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'h1;
localparam [1:0] ST_CONV = 2'h2;
localparam integer CONV_LAST_I = CONV_CLKS - 1;
localparam integer DIV_LAST_I = INT_HALF - 1;
localparam integer SER_LAST_I = `SER_LEN - 1;
localparam integer SER_LEAD_I = `SER_LEAD;
localparam [`CONV_CNT_W-1:0] CONV_LAST = CONV_LAST_I[`CONV_CNT_W-1:0];
localparam [`DIV_CNT_W-1:0] DIV_LAST = DIV_LAST_I[`DIV_CNT_W-1:0];
localparam [`SER_CNT_W-1:0] SER_LAST = SER_LAST_I[`SER_CNT_W-1:0];
localparam [`SER_CNT_W-1:0] SER_LEAD_N = SER_LEAD_I[`SER_CNT_W-1:0];

// Bipolar codes flip the msb of the offset code
function [`RES_W-1:0] encode;
    input [`RES_W-1:0] code;
    input unipolar;
    begin
        encode = unipolar ? code : {~code[`RES_W-1], code[`RES_W-2:0]};
    end
endfunction

// Bit of the serial word at a given position, position 0 sent first
function ser_bit;
    input [`SER_CNT_W-1:0] idx;
    input [`RES_W-1:0] code;
    input unipolar;
    reg [`RES_W-1:0] enc;
    reg [`SER_CNT_W-1:0] pos;
    begin
        enc = encode(code, unipolar);
        pos = SER_LAST - idx;
        if (idx < SER_LEAD_N) begin
            ser_bit = 1'b0;
        end else begin
            ser_bit = enc[pos[3:0]];
        end
    end
endfunction

// ----------------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------------
wire [`SYNC_W-1:0] sync_q;
wire cvs_s;
wire cs_s;
wire rd_s;
wire hbs_s;
wire ext_s;
wire [`FMT_W-1:0] fmt_s;

pin_sync #(
    .WIDTH(`SYNC_W),
    .RST_VAL(`SYNC_RST)
) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .d({format_sel, conv_clk_ext, db_in[`POS_HBS], rd_n, cs_n, convert_start_n}),
    .q(sync_q)
);

assign cvs_s = sync_q[0];
assign cs_s = sync_q[1];
assign rd_s = sync_q[2];
assign hbs_s = sync_q[3];
assign ext_s = sync_q[4];
assign fmt_s = sync_q[6:5];

// ----------------------------------------------------------------------------
// State
// ----------------------------------------------------------------------------
reg [1:0] st_r;
reg [1:0] st_nxt;
reg cvs_prev_r;
reg cs_prev_r;
reg rd_act_prev_r;
reg cclk_prev_r;
reg int_clk_r;
reg [`DIV_CNT_W-1:0] div_cnt_r;
reg [`CONV_CNT_W-1:0] conv_cnt_r;
reg [`CONV_CNT_W-1:0] conv_cnt_nxt;
reg mode2_r;
reg mode2_nxt;
reg int_n_r;
reg int_n_nxt;
reg [`RES_W-1:0] result_r;
reg [`RES_W-1:0] result_nxt;
reg ser_pend_r;
reg ser_pend_nxt;
reg ser_act_r;
reg ser_act_nxt;
reg [`SER_CNT_W-1:0] ser_cnt_r;
reg [`SER_CNT_W-1:0] ser_cnt_nxt;
reg sdat_r;
reg sdat_nxt;
reg [`RES_W-1:0] db_out_nxt;
reg [`RES_W-1:0] db_oe_nxt;

wire fmt_par;
wire fmt_cont;
wire cclk_lvl;
wire cclk_rise;
wire rd_act;
wire rd_start;
wire cvs_rise;
wire cs_fall;
wire idle;
wire start_m1;
wire start_m2;
wire conv_done;
wire drive_rd;
wire sclk_run;

assign fmt_par = fmt_s[`FMT_PAR_BIT];
// continuous clock at negative level only
assign fmt_cont = fmt_s[`FMT_NEG_BIT] & ~fmt_par;
assign cclk_lvl = use_ext_clk ? ext_s : int_clk_r;
assign cclk_rise = cclk_lvl & ~cclk_prev_r;
assign rd_act = ~cs_s & ~rd_s;
assign rd_start = rd_act & ~rd_act_prev_r;
assign cvs_rise = cvs_s & ~cvs_prev_r;
assign cs_fall = cs_prev_r & ~cs_s;
assign idle = st_r[0];
// start on rising edge, not while selected
assign start_m1 = idle & cvs_rise & cs_s;
// start by chip select with byte select low, or with any byte select in word format
assign start_m2 = idle & cs_fall & ~cvs_s & (fmt_par | ~hbs_s);
assign conv_done = st_r[1] & cclk_rise & (conv_cnt_r == CONV_LAST);
// latches frozen, no data lines driven by a read during conversion
// A read that starts a conversion must not drive the stale word
assign drive_rd = rd_act & idle & ~(start_m1 | start_m2);
assign sclk_run = fmt_cont | ser_act_r;

// ----------------------------------------------------------------------------
// Internal converter clock
// ----------------------------------------------------------------------------
// Runs always so the serial clock can be continuous
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        div_cnt_r <= {`DIV_CNT_W{1'b0}};
        int_clk_r <= 1'b0;
    end else if (clk_en) begin
        if (div_cnt_r == DIV_LAST) begin
            div_cnt_r <= {`DIV_CNT_W{1'b0}};
            int_clk_r <= ~int_clk_r;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end
end

// ----------------------------------------------------------------------------
// Conversion control
// ----------------------------------------------------------------------------
always @* begin
    st_nxt = st_r;
    conv_cnt_nxt = conv_cnt_r;
    mode2_nxt = mode2_r;
    int_n_nxt = int_n_r;
    result_nxt = result_r;
    case (st_r)
        ST_IDLE: begin
            if (start_m1 | start_m2) begin
                st_nxt = ST_CONV;
                conv_cnt_nxt = {`CONV_CNT_W{1'b0}};
                mode2_nxt = start_m2;
            end
        end
        ST_CONV: begin
            if (conv_done) begin
                st_nxt = ST_IDLE;
                result_nxt = encode(adc_code, unipolar_range);
            end else if (cclk_rise) begin
                conv_cnt_nxt = conv_cnt_r + 1'b1;
            end
        end
        default: begin
            st_nxt = ST_IDLE;
        end
    endcase
    if (rd_start) begin
        int_n_nxt = 1'b1;
    end
    // completion wins over a read in the same cycle
    if (conv_done & ~mode2_r) begin
        int_n_nxt = 1'b0;
    end
end

// ----------------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------------
always @* begin
    ser_pend_nxt = ser_pend_r;
    ser_act_nxt = ser_act_r;
    ser_cnt_nxt = ser_cnt_r;
    sdat_nxt = sdat_r;
    if (start_m1 | start_m2) begin
        ser_pend_nxt = ~fmt_par;
    end else if (cclk_rise) begin
        if (ser_pend_r) begin
            // strobe low at first clock rise
            ser_pend_nxt = 1'b0;
            ser_act_nxt = 1'b1;
            ser_cnt_nxt = {`SER_CNT_W{1'b0}};
            sdat_nxt = ser_bit({`SER_CNT_W{1'b0}}, adc_code, unipolar_range);
        end else if (ser_act_r) begin
            if (ser_cnt_r == SER_LAST) begin
                ser_act_nxt = 1'b0;
                sdat_nxt = 1'b1;
            end else begin
                ser_cnt_nxt = ser_cnt_r + 1'b1;
                sdat_nxt = ser_bit(ser_cnt_r + 1'b1, adc_code, unipolar_range);
            end
        end
    end
end

// ----------------------------------------------------------------------------
// Data bus drive
// ----------------------------------------------------------------------------
always @* begin
    db_out_nxt = {`RES_W{1'b0}};
    db_oe_nxt = {`RES_W{1'b0}};
    if (fmt_par) begin
        // full word on all twelve lines
        db_out_nxt = result_r;
        db_oe_nxt = {`RES_W{drive_rd}};
    end else begin
        if (hbs_s) begin
            db_out_nxt[`BYTE_W-1:0] = {{`NIB_W{1'b0}}, result_r[`RES_W-1:`BYTE_W]};
        end else begin
            db_out_nxt[`BYTE_W-1:0] = result_r[`BYTE_W-1:0];
        end
        db_oe_nxt[`BYTE_W-1:0] = {`BYTE_W{drive_rd}};
        // serial pins only pull low; top pin is an input
        db_oe_nxt[`POS_STRB] = ser_act_r;
        // gated clock stops after the frame
        db_oe_nxt[`POS_SCLK] = sclk_run & ~cclk_lvl;
        db_oe_nxt[`POS_SDAT] = ser_act_r & ~sdat_r;
    end
end

// ----------------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------------
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        st_r <= ST_IDLE;
        cvs_prev_r <= 1'b1;
        cs_prev_r <= 1'b1;
        rd_act_prev_r <= 1'b0;
        cclk_prev_r <= 1'b0;
        conv_cnt_r <= {`CONV_CNT_W{1'b0}};
        mode2_r <= 1'b0;
        int_n_r <= 1'b1;
        result_r <= `RES_RST;
        ser_pend_r <= 1'b0;
        ser_act_r <= 1'b0;
        ser_cnt_r <= {`SER_CNT_W{1'b0}};
        sdat_r <= 1'b1;
        db_out <= {`RES_W{1'b0}};
        db_oe <= {`RES_W{1'b0}};
        busy_int_n <= 1'b1;
        track_hold <= 1'b0;
    end else if (clk_en) begin
        st_r <= st_nxt;
        cvs_prev_r <= cvs_s;
        cs_prev_r <= cs_s;
        rd_act_prev_r <= rd_act;
        cclk_prev_r <= cclk_lvl;
        conv_cnt_r <= conv_cnt_nxt;
        mode2_r <= mode2_nxt;
        int_n_r <= int_n_nxt;
        result_r <= result_nxt;
        ser_pend_r <= ser_pend_nxt;
        ser_act_r <= ser_act_nxt;
        ser_cnt_r <= ser_cnt_nxt;
        sdat_r <= sdat_nxt;
        db_out <= db_out_nxt;
        db_oe <= db_oe_nxt;
        // busy follows conversion in mode 2
        busy_int_n <= mode2_nxt ? ~st_nxt[1] : int_n_nxt;
        track_hold <= st_nxt[1];
    end
end

endmodule // sampling_adc_host_interface

// *** include/sampling_adc_defs.vh ***
`ifndef SAMPLING_ADC_DEFS_VH
`define SAMPLING_ADC_DEFS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define RES_W 12
`define BYTE_W 8
`define NIB_W 4
`define SER_LEN 16
`define SER_LEAD 4
`define SER_CNT_W 5
`define CONV_CNT_W 8
`define DIV_CNT_W 8
`define SYNC_W 7

// ----------------------------------------------------------------------------
// Pin positions on the shared data bus
// ----------------------------------------------------------------------------
`define POS_HBS 11
`define POS_STRB 10
`define POS_SCLK 9
`define POS_SDAT 8

// ----------------------------------------------------------------------------
// Three-level format input, as two digital sense bits
// ----------------------------------------------------------------------------
`define FMT_W 2
`define FMT_HIGH 2'h1
`define FMT_ZERO 2'h0
`define FMT_NEG 2'h2
`define FMT_PAR_BIT 0
`define FMT_NEG_BIT 1

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define CONV_CLKS_DEF 20
`define INT_HALF_DEF 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SYNC_RST 7'h7F
`define RES_RST 12'h000

`endif

// *** sim/adc_checker.sv ***
`include "sampling_adc_defs.vh"
module adc_checker #(
    parameter CONV_CLKS = `CONV_CLKS_DEF,
    parameter INT_HALF = `INT_HALF_DEF
) (
    input wire clk_sys,
    input wire resetn,
    input wire clk_en,
    input wire convert_start_n,
    input wire cs_n,
    input wire rd_n,
    input wire [`RES_W-1:0] db_in,
    input wire conv_clk_ext,
    input wire use_ext_clk,
    input wire [`FMT_W-1:0] format_sel,
    input wire unipolar_range,
    input wire [`RES_W-1:0] adc_code,
    input wire [`RES_W-1:0] db_out,
    input wire [`RES_W-1:0] db_oe,
    input wire busy_int_n,
    input wire track_hold
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // --------------------------------------------------------------------
    // Pin windows, long enough to cover the two-flop synchronisers
    // --------------------------------------------------------------------
    sequence cs_idle_s; cs_n[*3]; endsequence
    sequence cs_held_s; (!cs_n)[*6]; endsequence
    sequence byte_fmt_s; (!format_sel[`FMT_PAR_BIT])[*4]; endsequence
    sequence word_fmt_s; (format_sel == `FMT_HIGH)[*4]; endsequence
    sequence hi_sel_s; (!format_sel[`FMT_PAR_BIT] && db_in[`POS_HBS])[*5]; endsequence
    mode1_start_a: assert property (
        cs_idle_s ##0 ($rose(convert_start_n) && !track_hold) |-> ##[1:4] track_hold)
        else $error("hold not entered after convert start");
    cs_block_a: assert property (
        cs_held_s ##0 ($rose(convert_start_n) && !track_hold) ##1 (!cs_n)[*4] |-> !track_hold)
        else $error("conversion started while selected");
    int_set_a: assert property (
        $fell(track_hold) && convert_start_n |-> ##[0:1] !busy_int_n)
        else $error("interrupt not raised at completion");
    int_clear_a: assert property (
        !busy_int_n && !track_hold && convert_start_n && $fell(cs_n | rd_n) |-> ##[1:4] busy_int_n)
        else $error("interrupt not released by read");
    busy_hold_a: assert property (
        track_hold && !convert_start_n |-> !busy_int_n)
        else $error("busy high during conversion");
    no_read_conv_a: assert property (
        track_hold |-> db_oe[7:0] == 8'h00)
        else $error("data driven during conversion");
    word_all_a: assert property (
        word_fmt_s ##0 db_oe[0] |-> db_oe == 12'hFFF)
        else $error("word read not driving all lines");
    nibble_zero_a: assert property (
        hi_sel_s ##0 db_oe[0] |-> db_out[7:4] == 4'h0 && !db_oe[`POS_HBS])
        else $error("high byte read malformed");
    strobe_soon_a: assert property (
        byte_fmt_s ##0 $rose(track_hold) |-> ##[1:72] db_oe[`POS_STRB])
        else $error("strobe late");
    open_drain_a: assert property (
        byte_fmt_s |-> db_out[`POS_STRB:`POS_SDAT] == 3'h0)
        else $error("serial pin driven high");
endmodule // adc_checker

bind sampling_adc_host_interface adc_checker #(.CONV_CLKS(CONV_CLKS), .INT_HALF(INT_HALF)) chk (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .convert_start_n(convert_start_n),
    .cs_n(cs_n), .rd_n(rd_n), .db_in(db_in), .conv_clk_ext(conv_clk_ext),
    .use_ext_clk(use_ext_clk), .format_sel(format_sel), .unipolar_range(unipolar_range),
    .adc_code(adc_code), .db_out(db_out), .db_oe(db_oe), .busy_int_n(busy_int_n),
    .track_hold(track_hold)
);

// *** sim/host_model.sv ***
module host_model (
    input wire clk_sys,
    input wire busy_int_n,
    input wire [11:0] db_out,
    input wire [11:0] db_oe,
    output logic convert_start_n,
    output logic cs_n,
    output logic rd_n,
    output logic byte_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        convert_start_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        byte_sel = 1'b0;
    end
    task automatic start_pulse();
        @(negedge clk_sys) convert_start_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        convert_start_n = 1'b1;
    endtask
    task automatic blocked_start();
        @(negedge clk_sys) cs_n = 1'b0;
        byte_sel = 1'b1;
        repeat (6) @(negedge clk_sys);
        start_pulse();
        repeat (8) @(negedge clk_sys);
        cs_n = 1'b1;
    endtask
    task automatic enter_mode2();
        @(negedge clk_sys) convert_start_n = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask
    // one read waits out busy; slow stretches the strobe
    task automatic bus_read(input logic sel, input int slow, output logic [11:0] d, oe);
        int n;
        @(negedge clk_sys);
        byte_sel = sel;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        for (n = 0; n < 1000 && busy_int_n !== 1'b1; n++) @(negedge clk_sys);
        repeat (4 + slow) @(negedge clk_sys);
        d = db_out;
        oe = db_oe;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask
endmodule // host_model

// *** sim/testbench.sv ***
`include "sampling_adc_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, resetn, conv_clk_ext, use_ext_clk, unipolar_range, busy_int_n, track_hold;
    logic [1:0] format_sel;
    logic [11:0] adc_code, db_out, db_oe, pins, d, oe;
    logic sclk_q, clk_en;
    wire cv_n, cs_n, rd_n, sel;
    logic [31:0] seed;
    logic [15:0] sword;
    int err_total, cmp_count, nbits, sfall;
    int exp_q[$];
    logic [1:0] fmt_tab[3] = '{`FMT_HIGH, `FMT_ZERO, `FMT_NEG};
    // Pull-ups on released lines 10 to 0, line 11 carries the byte select, so a released pin never reads as stale data
    assign pins = (db_oe & db_out) | (~db_oe & {sel, 11'h7FF});
    sampling_adc_host_interface #(.CONV_CLKS(17), .INT_HALF(2)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .convert_start_n(cv_n),
        .cs_n(cs_n), .rd_n(rd_n), .db_in(pins), .conv_clk_ext(conv_clk_ext),
        .use_ext_clk(use_ext_clk), .format_sel(format_sel), .unipolar_range(unipolar_range),
        .adc_code(adc_code), .db_out(db_out), .db_oe(db_oe), .busy_int_n(busy_int_n),
        .track_hold(track_hold)
    );
    host_model host (.clk_sys(clk_sys), .busy_int_n(busy_int_n), .db_out(db_out),
        .db_oe(db_oe), .convert_start_n(cv_n), .cs_n(cs_n), .rd_n(rd_n), .byte_sel(sel));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Odd offset keeps the converter clock out of phase with the system clock
    initial begin
        conv_clk_ext = 1'b0;
        #7;
        forever #40 conv_clk_ext = ~conv_clk_ext;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [11:0] enc(input int c, input int uni);
        return uni ? 12'(c) : 12'(c ^ 2048);
    endfunction
    // --------------------------------------------------------------------
    // Serial pins as seen behind the pull-ups; bits count only in a frame
    // --------------------------------------------------------------------
    always @(posedge clk_sys) begin
        sclk_q <= pins[`POS_SCLK];
        if (sclk_q && !pins[`POS_SCLK]) begin
            sfall++;
            if (track_hold && !pins[`POS_STRB]) begin
                sword = {sword[14:0], pins[`POS_SDAT]};
                nbits++;
            end
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_read(input logic [1:0] fmt, input logic hs, input logic [11:0] r);
        if (fmt == `FMT_HIGH) begin
            chk(oe, 12'hFFF);
            chk(d, r);
        end else begin
            chk({3'h0, oe[11], oe[7:0]}, 12'h0FF);
            chk({4'h0, d[7:0]}, hs ? {8'h0, r[11:8]} : {4'h0, r[7:0]});
        end
    endtask
    task automatic run_conv(input logic m2, input logic [1:0] fmt);
        logic [11:0] r;
        logic hs;
        int n;
        seed = xs(seed);
        @(negedge clk_sys);
        format_sel = fmt;
        use_ext_clk = seed[3];
        unipolar_range = seed[4];
        adc_code = seed[27:16];
        hs = seed[5] & !m2;
        exp_q.push_back(enc(seed[27:16], seed[4]));
        repeat (8) @(negedge clk_sys);
        nbits = 0;
        if (m2) begin
            host.bus_read(1'b0, seed[9:8], d, oe);
        end else begin
            host.start_pulse();
            host.bus_read(1'b0, seed[9:8], d, oe);
            chk(oe & 12'h0FF, 12'h000);
            for (n = 0; n < 1000 && busy_int_n !== 1'b0; n++) @(negedge clk_sys);
            chk({11'h0, busy_int_n}, 12'h000);
            host.bus_read(hs, seed[11:10], d, oe);
        end
        r = exp_q.pop_front();
        chk({11'h0, track_hold}, 12'h000);
        chk({11'h0, busy_int_n}, 12'h001);
        chk(12'(nbits), fmt == `FMT_HIGH ? 12'd0 : 12'd16);
        chk_read(fmt, hs, r);
        if (fmt != `FMT_HIGH) begin
            chk(sword[11:0], r);
            chk({8'h0, sword[15:12]}, 12'h000);
            host.bus_read(!hs, 0, d, oe);
            chk_read(fmt, !hs, r);
        end
        sfall = 0;
        repeat (60) @(negedge clk_sys);
        chk(12'(sfall != 0), 12'(fmt == `FMT_NEG));
    endtask
    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #150us;
        err_total++;
        stop_test();
    end
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        use_ext_clk = 1'b0;
        unipolar_range = 1'b0;
        format_sel = `FMT_HIGH;
        adc_code = 12'h000;
        seed = 32'h1EF3;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        host.bus_read(1'b0, 0, d, oe);
        chk({11'h0, busy_int_n}, 12'h001);
        @(negedge clk_sys) format_sel = `FMT_ZERO;
        host.blocked_start();
        repeat (4) @(negedge clk_sys);
        chk({11'h0, track_hold}, 12'h000);
        // Low clock enable must hold a running conversion
        host.start_pulse();
        repeat (20) @(negedge clk_sys);
        clk_en = 1'b0;
        repeat (200) @(negedge clk_sys);
        chk({11'h0, track_hold}, 12'h001);
        clk_en = 1'b1;
        for (int n = 0; n < 1000 && busy_int_n !== 1'b0; n++) @(negedge clk_sys);
        chk({11'h0, busy_int_n}, 12'h000);
        host.bus_read(1'b0, 0, d, oe);
        chk({11'h0, busy_int_n}, 12'h001);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) host.enter_mode2();
            run_conv(i >= 6, fmt_tab[i % 3]);
        end
        stop_test();
    end
endmodule // testbench
